// ==== sarp_top.sv ====
// Bus port and conversion sequencer of a 12-bit converter.
// Assumes host pins and the analog code arrive asynchronous to CORE_CLK.
`timescale 1ns/1ps
`default_nettype none
`include "sarp_consts.svh"

// Function
// - Chip select low needed for start and read
// - Chip select high ignores write, read, byte select and width
// - Write low starts conversion, a write during counting restarts it
// - Narrow read, byte select low: bits 0-7
// - Narrow read, byte select high: bits 8-11, over-range
// - Narrow mode: byte select picks output byte
// - Wide mode drives both bytes together
// - Active high, bit 11 most significant
// - Done low while busy, high when complete
// - Over-range valid at end, above full scale
// - Over-range enabled only with high byte
// - Twenty oscillator cycles, then result latched
// - Last three cycles: auto-zero, clear registers
// - Done falls one to two periods after write
module sarp_top #(
  parameter int OSC_DIV     = `SARP_OSC_DIV,
  parameter int CONV_CYCLES = `SARP_CONV_CYCLES,
  parameter int AZ_CYCLES   = `SARP_AZ_CYCLES
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  input  wire logic        CS_N,
  input  wire logic        WR_N,
  input  wire logic        RD_N,
  input  wire logic        BYTE_SELECT,
  input  wire logic        BUS_WIDE,
  input  wire logic [12:0] ANALOG_CODE,
  output var  logic [11:0] RESULT_BITS,
  output var  logic [11:0] RESULT_BITS_OE,
  output var  logic        OVER_RANGE_FLAG,
  output var  logic        OVER_RANGE_FLAG_OE,
  output var  logic        CONV_DONE,
  output var  logic        AUTO_ZERO,
  output var  logic        OSCILLATOR_OUT
);

  // Widths of the internal counters
  localparam int DIV_W = $clog2(OSC_DIV);
  localparam int CNT_W = $clog2(CONV_CYCLES);
  // Last divider count, half-period divider count and last conversion cycle
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(OSC_DIV / 2);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);
  // Cycle at whose end the accumulated code is complete
  localparam logic [CNT_W-1:0] CNT_ACC  = CNT_W'(CONV_CYCLES - AZ_CYCLES - 1);
  // Bound for done to fall after a start, in core cycles
  localparam int DONE_FALL_MAX = 2 * OSC_DIV + 3;

  // Refuse settings the sequencer cannot serve
  initial begin
    if (OSC_DIV < 4 || CONV_CYCLES < AZ_CYCLES + 2 || AZ_CYCLES < 1) begin
      $error("sarp_top: unusable divider or cycle counts");
    end
  end

  // Reset release chain
  logic rst_s1;    // First stage
  logic rst_n;     // Released reset used inside

  // Reset released through two flip-flops
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // Pin synchronisers
  sarp_pkg::sarp_ctl_t ctl_s1;   // First stage, read only by ctl_s2
  sarp_pkg::sarp_ctl_t ctl_s2;   // Usable control pins
  sarp_pkg::sarp_ctl_t pin_ctl;  // Raw pins gathered
  logic [12:0]         code_s1;  // First stage of analog code
  logic [12:0]         code_s2;  // Usable analog code

  // Gather raw pins into one carrier
  always_comb begin
    pin_ctl.cs_n     = CS_N;
    pin_ctl.wr_n     = WR_N;
    pin_ctl.rd_n     = RD_N;
    pin_ctl.byte_sel = BYTE_SELECT;
    pin_ctl.bus_wide = BUS_WIDE;
  end

  // Two flip-flops on every pin; idle level is deselected
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctl_s1  <= '1;
      ctl_s2  <= '1;
      code_s1 <= 13'h0000;
      code_s2 <= 13'h0000;
    end else begin
      ctl_s1  <= pin_ctl;
      ctl_s2  <= ctl_s1;
      code_s1 <= ANALOG_CODE;
      code_s2 <= code_s1;
    end
  end

  // Command decode
  logic selected;   // Chip selected
  logic start_req;  // Start level
  logic read_act;   // Read in progress

  // Nothing acts unless selected
  always_comb begin
    selected  = !ctl_s2.cs_n;
    start_req = selected && !ctl_s2.wr_n;
    read_act  = selected && !ctl_s2.rd_n;
  end

  // Oscillator divider
  logic [DIV_W-1:0] div_cnt;       // Divider count
  logic [DIV_W-1:0] next_div_cnt;  // Next divider count
  logic             osc_tick;      // One oscillator period ends
  logic             next_osc_out;  // Next oscillator level

  // Divider wraps every oscillator period
  always_comb begin
    osc_tick     = (div_cnt == DIV_LAST);
    next_div_cnt = osc_tick ? '0 : div_cnt + 1'b1;
    next_osc_out = (next_div_cnt < DIV_HALF);
  end

  // Divider registers
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt        <= '0;
      OSCILLATOR_OUT <= 1'b0;
    end else begin
      div_cnt        <= next_div_cnt;
      OSCILLATOR_OUT <= next_osc_out;
    end
  end

  // Conversion sequencer
  sarp_pkg::sarp_state_t state;       // Current state
  sarp_pkg::sarp_state_t next_state;  // Next state
  logic [CNT_W-1:0]      cnt;         // Oscillator cycle of conversion
  logic [CNT_W-1:0]      next_cnt;    // Next cycle count
  logic [12:0]           acc;         // Accumulated code
  logic [12:0]           next_acc;    // Next accumulated code
  logic [11:0]           result;      // Latched result
  logic [11:0]           next_result; // Next latched result
  logic                  over_range_flag;         // Latched over-range
  logic                  next_ovr;    // Next over-range
  logic                  done;        // Conversion complete
  logic                  next_done;   // Next complete flag

  // Start, count, accumulate, auto-zero, latch
  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_acc    = acc;
    next_result = result;
    next_ovr    = over_range_flag;
    next_done   = done;
    case (state)
      // Wait for a start
      sarp_pkg::SARP_IDLE: begin
        if (start_req) begin
          next_state = sarp_pkg::SARP_ARM1;
        end
      end
      // First oscillator edge after start
      sarp_pkg::SARP_ARM1: begin
        if (osc_tick) begin
          next_state = sarp_pkg::SARP_ARM2;
        end
      end
      // Second edge: busy shows, conversion begins
      sarp_pkg::SARP_ARM2: begin
        if (osc_tick) begin
          next_state = sarp_pkg::SARP_CONV;
          next_cnt   = '0;
          next_done  = 1'b0;
        end
      end
      // Counting oscillator cycles
      sarp_pkg::SARP_CONV: begin
        if (osc_tick) begin
          if (start_req) begin
            next_cnt = '0;
            next_acc = 13'h0000;
          end else if (cnt == CNT_LAST) begin
            next_state  = sarp_pkg::SARP_IDLE;
            next_result = acc[11:0];
            next_ovr    = acc[12];
            next_acc    = 13'h0000;
            next_done   = 1'b1;
          end else begin
            if (cnt == CNT_ACC) begin
              next_acc = code_s2;
            end
            next_cnt = cnt + 1'b1;
          end
        end
      end
      default: begin
        next_state = sarp_pkg::SARP_IDLE;
      end
    endcase
  end

  // Sequencer registers; done starts high, nothing pending
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state  <= sarp_pkg::SARP_IDLE;
      cnt    <= '0;
      acc    <= 13'h0000;
      result <= 12'h0000;
      over_range_flag    <= 1'b0;
      done   <= 1'b1;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      acc    <= next_acc;
      result <= next_result;
      over_range_flag    <= next_ovr;
      done   <= next_done;
    end
  end

  // Auto-zero in the closing cycles
  always_comb begin
    AUTO_ZERO = (state == sarp_pkg::SARP_CONV) && (cnt > CNT_ACC);
    CONV_DONE = done;
    RESULT_BITS     = result;
    OVER_RANGE_FLAG = over_range_flag;
  end

  // Output enables
  logic lo_oe;       // Low byte enabled
  logic hi_oe;       // High byte and over-range enabled
  logic next_lo_oe;  // Next low enable
  logic next_hi_oe;  // Next high enable

  // Byte steering from select and width
  always_comb begin
    next_lo_oe = read_act && (ctl_s2.bus_wide || !ctl_s2.byte_sel);
    next_hi_oe = read_act && (ctl_s2.bus_wide || ctl_s2.byte_sel);
  end

  // Enable registers, released off the bus
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      lo_oe <= 1'b0;
      hi_oe <= 1'b0;
    end else begin
      lo_oe <= next_lo_oe;
      hi_oe <= next_hi_oe;
    end
  end

  // Enables spread over the pins
  always_comb begin
    RESULT_BITS_OE     = {{(12 - `SARP_LO_BITS){hi_oe}}, {`SARP_LO_BITS{lo_oe}}};
    OVER_RANGE_FLAG_OE = hi_oe;
  end

  // Checks
  chk_idle_outputs_off: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    !read_act |=> (RESULT_BITS_OE == 12'h000) && !OVER_RANGE_FLAG_OE)
    else $error("outputs driven without a read");

  chk_low_byte_only: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    read_act && !ctl_s2.bus_wide && !ctl_s2.byte_sel |=> (RESULT_BITS_OE == 12'h0FF))
    else $error("low byte read wrong enables");

  chk_high_byte_only: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    read_act && !ctl_s2.bus_wide && ctl_s2.byte_sel |=> (RESULT_BITS_OE == 12'hF00) && OVER_RANGE_FLAG_OE)
    else $error("high byte read wrong enables");

  chk_wide_read_all: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    read_act && ctl_s2.bus_wide |=> (RESULT_BITS_OE == 12'hFFF) && OVER_RANGE_FLAG_OE)
    else $error("wide read not all bytes");

  chk_ovr_with_high: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    OVER_RANGE_FLAG_OE == RESULT_BITS_OE[11])
    else $error("over-range enable apart from high byte");

  chk_done_falls: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (state == sarp_pkg::SARP_IDLE) && start_req && done |-> ##[OSC_DIV:DONE_FALL_MAX] !CONV_DONE)
    else $error("done did not fall after start");

  chk_latch_at_end: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (state == sarp_pkg::SARP_CONV) && osc_tick && (cnt == CNT_LAST) && !start_req
    |=> CONV_DONE && ({OVER_RANGE_FLAG, RESULT_BITS} == $past(acc)) && (acc == 13'h0000))
    else $error("result not latched at final cycle");

  chk_result_stable: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    !CONV_DONE |-> $stable(RESULT_BITS) && $stable(OVER_RANGE_FLAG))
    else $error("result changed while busy");

endmodule
`default_nettype wire

// ==== sarp_consts.svh ====
// Constants for the converter bus port: timing counts and widths.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SARP_CONSTS_SVH
`define SARP_CONSTS_SVH
// Core clock period in ns
`define SARP_CLK_PERIOD_NS 5
// Converter oscillator period in ns (500 kHz)
`define SARP_OSC_PERIOD_NS 2000
// Core cycles per oscillator period
`define SARP_OSC_DIV (`SARP_OSC_PERIOD_NS / `SARP_CLK_PERIOD_NS)
// Oscillator cycles per conversion
`define SARP_CONV_CYCLES 20
// Closing cycles spent on auto-zero and reset
`define SARP_AZ_CYCLES 3
// Result width in bits
`define SARP_RES_BITS 12
// Width of the low result byte
`define SARP_LO_BITS 8
`endif

// ==== sarp_pkg.sv ====
// Types shared by the converter bus port.
// Assumes sarp_consts.svh is on the include path.
`include "sarp_consts.svh"
package sarp_pkg;
  // Host control pins, kept together through the synchroniser
  typedef struct packed {
    logic cs_n;       // Chip select, active low
    logic wr_n;       // Write strobe, active low
    logic rd_n;       // Read strobe, active low
    logic byte_sel;   // Byte select
    logic bus_wide;   // Width select
  } sarp_ctl_t;
  // Conversion sequencer states
  typedef enum logic [1:0] {
    SARP_IDLE,
    SARP_ARM1,
    SARP_ARM2,
    SARP_CONV
  } sarp_state_t;
endpackage

// ==== sarp_host.sv ====
// Host bus model: drives the converter's control pins and resolves its data bus.
// Assumes the testbench calls hold() and supplies the core clock.
`timescale 1ns/1ps
`default_nettype none
module sarp_host (
  input  wire logic                clk,
  input  wire logic [11:0]         res,
  input  wire logic [11:0]         res_oe,
  input  wire logic                over_range_flag,
  input  wire logic                ovr_oe,
  output var  sarp_pkg::sarp_ctl_t ctl,
  output var  logic [12:0]         bus
);
  logic [12:0] oe;                 // Enables of all bus bits
  logic [12:0] float_pat = '0;     // Undriven bits toggle so stale data never passes

  assign oe = {ovr_oe, res_oe};

  // Undriven pattern flips every cycle
  always @(posedge clk) begin
    float_pat <= ~float_pat;
  end

  // Bus level: device value where enabled, toggling pattern elsewhere
  always_comb begin
    bus = ({over_range_flag, res} & oe) | (float_pat & ~oe);
  end

  // Pins start deselected
  initial begin
    ctl = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  end

  // Apply a pin set after a falling edge, hold it n cycles
  task automatic hold(input sarp_pkg::sarp_ctl_t v, input int n);
    @(negedge clk);
    ctl = v;
    repeat (n) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ==== tb_sarp_top.sv ====
// Self-checking bench for the converter bus port.
// Assumes the host model sarp_host and a fast oscillator divider.
`timescale 1ns/1ps
`default_nettype none
module tb_sarp_top;
  localparam int OSC = 8;              // Short oscillator divider
  logic                clk   = 1'b0;   // Core clock, 5 ns
  logic                rst_n = 1'b0;   // Active-low reset
  logic [12:0]         code  = '0;     // Stand-in analog code
  logic [11:0]         res;            // Result value
  logic [11:0]         res_oe;         // Result enables
  logic                over_range_flag;            // Over-range value
  logic                ovr_oe;         // Over-range enable
  logic                done;           // Conversion done
  logic                az;             // Auto-zero window
  logic                osc;            // Divided oscillator level
  int                  osc_hi = 0;     // High samples of the oscillator
  sarp_pkg::sarp_ctl_t ctl;            // Host control pins
  logic [12:0]         bus;            // Resolved data bus
  int                  miscompares = 0;
  int                  check_count = 0;
  int                  cyc = 0;        // Timeout counter

  always #2.5 clk = ~clk;

  sarp_top #(.OSC_DIV(OSC)) u_dut (
    .CORE_CLK(clk), .RESET_N(rst_n), .CS_N(ctl.cs_n), .WR_N(ctl.wr_n), .RD_N(ctl.rd_n),
    .BYTE_SELECT(ctl.byte_sel), .BUS_WIDE(ctl.bus_wide), .ANALOG_CODE(code),
    .RESULT_BITS(res), .RESULT_BITS_OE(res_oe), .OVER_RANGE_FLAG(over_range_flag),
    .OVER_RANGE_FLAG_OE(ovr_oe), .CONV_DONE(done), .AUTO_ZERO(az), .OSCILLATOR_OUT(osc)
  );

  sarp_host u_host (
    .clk(clk), .res(res), .res_oe(res_oe), .over_range_flag(over_range_flag), .ovr_oe(ovr_oe), .ctl(ctl), .bus(bus)
  );

  // Verdict and end of run
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Compare and count
  task automatic check(input logic [12:0] got, input logic [12:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One read cycle, then release and confirm the bus floats
  task automatic rd(input logic cs_n, input logic sel, input logic wide,
                    input logic [12:0] exp_en, input logic [12:0] exp_val);
    u_host.hold('{cs_n, 1'b1, 1'b0, sel, wide}, 4);
    check({ovr_oe, res_oe}, exp_en, "enables");
    check(bus & exp_en, exp_val, "data");
    u_host.hold('{1'b1, 1'b1, 1'b1, 1'b0, 1'b0}, 4);
    check({ovr_oe, res_oe}, 13'h0000, "released enables");
  endtask

  // Start a conversion, time done fall, busy length and auto-zero window
  task automatic convert(input logic [12:0] c, input logic [2:0] noise);
    int t_fall;
    int t_low;
    int t_az;
    code = c;
    t_fall = 4;
    t_low = 0;
    t_az = 0;
    u_host.hold('{1'b0, 1'b0, noise[2], noise[1], noise[0]}, 4);
    u_host.hold('{1'b1, 1'b1, 1'b1, 1'b0, 1'b0}, 0);
    while (done !== 1'b0 && t_fall < 40) begin
      @(negedge clk);
      t_fall++;
    end
    check({12'h000, t_fall >= OSC && t_fall <= 2 * OSC + 4}, 13'h0001, "done fall delay");
    while (done !== 1'b1 && t_low < 400) begin
      @(negedge clk);
      t_low++;
      if (az === 1'b1) t_az++;
    end
    check(13'(t_low), 13'(20 * OSC), "busy length");
    check(13'(t_az), 13'(3 * OSC), "auto-zero length");
    check({12'h000, az}, 13'h0000, "auto-zero off");
  endtask

  // Start, then a second write in mid-conversion restarts the count
  task automatic reconvert(input logic [12:0] c);
    int t_low;
    t_low = 0;
    u_host.hold('{1'b0, 1'b0, 1'b1, 1'b0, 1'b0}, 4);
    u_host.hold('{1'b1, 1'b1, 1'b1, 1'b0, 1'b0}, 0);
    while (done !== 1'b0 && t_low < 40) begin
      @(negedge clk);
      t_low++;
    end
    check({12'h000, done}, 13'h0000, "busy before restart");
    // Write low for exactly one divider period lands on one wrap only
    repeat (5 * OSC - 4) @(negedge clk);
    code = c;
    u_host.hold('{1'b0, 1'b0, 1'b1, 1'b0, 1'b0}, OSC - 1);
    u_host.hold('{1'b1, 1'b1, 1'b1, 1'b0, 1'b0}, 0);
    t_low = 6 * OSC - 3;
    while (done !== 1'b1 && t_low < 400) begin
      @(negedge clk);
      t_low++;
    end
    check(13'(t_low), 13'(25 * OSC), "restarted busy length");
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  // Main sequence
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    check({12'h000, done}, 13'h0001, "done after reset");
    check({ovr_oe, res_oe}, 13'h0000, "idle enables");
    // Oscillator output: half of each divider period high
    repeat (OSC) begin
      @(negedge clk);
      if (osc === 1'b1) osc_hi++;
    end
    check(13'(osc_hi), 13'(OSC / 2), "oscillator duty");
    // Deselected: write, read and width strobes all active
    u_host.hold('{1'b1, 1'b0, 1'b0, 1'b1, 1'b1}, 40);
    check({12'h000, done}, 13'h0001, "no start deselected");
    check({ovr_oe, res_oe}, 13'h0000, "no enable deselected");
    u_host.hold('{1'b1, 1'b1, 1'b1, 1'b0, 1'b0}, 4);
    // Start with read, byte and width strobes active too
    convert(13'h15A3, 3'b011);
    rd(1'b0, 1'b0, 1'b0, 13'h00FF, 13'h00A3);
    rd(1'b0, 1'b1, 1'b0, 13'h1F00, 13'h1500);
    rd(1'b0, 1'b0, 1'b1, 13'h1FFF, 13'h15A3);
    rd(1'b0, 1'b1, 1'b1, 13'h1FFF, 13'h15A3);
    rd(1'b1, 1'b0, 1'b0, 13'h0000, 13'h0000);
    // Full scale without over-range
    convert(13'h0FFF, 3'b100);
    rd(1'b0, 1'b1, 1'b0, 13'h1F00, 13'h0F00);
    rd(1'b0, 1'b0, 1'b1, 13'h1FFF, 13'h0FFF);
    // Second write mid-conversion restarts the count
    reconvert(13'h0123);
    rd(1'b0, 1'b0, 1'b1, 13'h1FFF, 13'h0123);
    finish_test();
  end
endmodule
`default_nettype wire
